// *** rtl/branch_unit_consts.svh ***
// Functional notes
// - Displacement is sign-extended offset times two.
// - Displacement adds to instruction address plus two.
// - Unconditional branch always loads the target.
// - Nonzero branch taken when zero flag clear.
// - Zero branch taken when zero flag set.
// - Plus branch taken when negative flag clear.
// - Minus branch taken when negative flag set.
// - Overflow-clear branch taken when overflow clear.
// - Overflow-set branch taken when overflow set.
// - Carry-clear branch taken when carry clear.
// - Carry-set branch taken when carry set.
// - Signed greater-or-equal taken when negative equals overflow.
// - Signed less-than taken when negative xor overflow.
// - Signed greater-than as greater-or-equal, not on zero.
// - Signed less-or-equal is less-than or zero set.
// - Unsigned higher taken when carry and zero clear.
// - Unsigned lower-or-same taken when carry or zero.
// - Unsigned higher-or-same equals carry-clear opcode.
// - Unsigned lower equals carry-set opcode.
// - Signed tests order words as two's complement.
// - Unsigned tests order words as plain unsigned.
`ifndef BRANCH_UNIT_CONSTS_SVH
`define BRANCH_UNIT_CONSTS_SVH

// Instruction word fields.
`define BCU_OPC_HI 15
`define BCU_OPC_LO 8
`define BCU_OFF_HI 7
`define BCU_OFF_LO 0
`define BCU_OFF_SIGN 7

// Opcode byte of each branch.
`define BCU_OPC_ALWAYS 8'h01
`define BCU_OPC_NONZERO 8'h02
`define BCU_OPC_ZERO 8'h03
`define BCU_OPC_SIGNED_GE 8'h04
`define BCU_OPC_SIGNED_LT 8'h05
`define BCU_OPC_SIGNED_GT 8'h06
`define BCU_OPC_SIGNED_LE 8'h07
`define BCU_OPC_PLUS 8'h80
`define BCU_OPC_MINUS 8'h81
`define BCU_OPC_UNS_HIGHER 8'h82
`define BCU_OPC_UNS_LOWER_SAME 8'h83
`define BCU_OPC_OVF_CLEAR 8'h84
`define BCU_OPC_OVF_SET 8'h85
`define BCU_OPC_CARRY_CLEAR 8'h86
`define BCU_OPC_CARRY_SET 8'h87
`define BCU_OPC_UNS_HIGHER_SAME `BCU_OPC_CARRY_CLEAR
`define BCU_OPC_UNS_LOWER `BCU_OPC_CARRY_SET

// Step from an instruction to the next word, in bytes.
`define BCU_WORD_STEP 16'h0002

// Reset values of the result stage.
`define BCU_RST_PC 16'h0000
`define BCU_RST_FLAGS 4'h0

// Flag positions in the packed flag vector.
`define BCU_FLAG_N 3
`define BCU_FLAG_Z 2
`define BCU_FLAG_V 1
`define BCU_FLAG_C 0

`endif

// *** rtl/branch_unit_pkg.sv ***
package branch_unit_pkg;

  // Branch classes recognised by the decoder.
  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_ALWAYS,
    KIND_NONZERO,
    KIND_ZERO,
    KIND_PLUS,
    KIND_MINUS,
    KIND_OVF_CLEAR,
    KIND_OVF_SET,
    KIND_CARRY_CLEAR,
    KIND_CARRY_SET,
    KIND_SIGNED_GE,
    KIND_SIGNED_LT,
    KIND_SIGNED_GT,
    KIND_SIGNED_LE,
    KIND_UNS_HIGHER,
    KIND_UNS_LOWER_SAME
  } branch_kind_t;

  // Condition flags as seen by the branch tests.
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cond_flags_t;

endpackage : branch_unit_pkg

// *** rtl/branch_cond_eval.sv ***
`timescale 1ns/100ps
module branch_cond_eval
  import branch_unit_pkg::*;
(
  input wire branch_kind_t kind, // Decoded branch class.
  input wire cond_flags_t flags, // Current condition flags.
  output logic cond_met // High when the branch is to be taken.
);

  logic n_xor_v;

  // Signed tests read N xor V, which gives two's complement order even after overflow.
  assign n_xor_v = flags.n ^ flags.v;

  // Condition test per branch class.
  always_comb
  begin
    unique case (kind)
      KIND_NONE: cond_met = 1'b0;
      KIND_ALWAYS: cond_met = 1'b1;
      KIND_NONZERO: cond_met = ~flags.z;
      KIND_ZERO: cond_met = flags.z;
      KIND_PLUS: cond_met = ~flags.n;
      KIND_MINUS: cond_met = flags.n;
      KIND_OVF_CLEAR: cond_met = ~flags.v;
      KIND_OVF_SET: cond_met = flags.v;
      KIND_CARRY_CLEAR: cond_met = ~flags.c;
      KIND_CARRY_SET: cond_met = flags.c;
      KIND_SIGNED_GE: cond_met = ~n_xor_v;
      KIND_SIGNED_LT: cond_met = n_xor_v;
      KIND_SIGNED_GT: cond_met = ~(flags.z | n_xor_v);
      KIND_SIGNED_LE: cond_met = flags.z | n_xor_v;
      KIND_UNS_HIGHER: cond_met = ~(flags.c | flags.z);
      KIND_UNS_LOWER_SAME: cond_met = flags.c | flags.z;
    endcase
  end

endmodule : branch_cond_eval

// *** rtl/branch_condition_unit.sv ***
`timescale 1ns/100ps
`include "branch_unit_consts.svh"
module branch_condition_unit
  import branch_unit_pkg::*;
#(
  parameter int ADDR_W = 16 // Width of the program counter in bits.
)
(
  input wire logic clk, // Processor clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic dec_valid, // Decode stage presents an instruction.
  input wire logic [15:0] dec_word, // Instruction word.
  input wire logic [ADDR_W-1:0] dec_addr, // Byte address of the instruction.
  input wire logic flag_n, // Negative flag.
  input wire logic flag_z, // Zero flag.
  input wire logic flag_v, // Overflow flag.
  input wire logic flag_c, // Carry flag.
  output logic res_valid, // Result stage holds a decoded instruction.
  output logic res_is_branch, // The instruction is a branch.
  output logic res_taken, // The branch condition held.
  output logic res_load_pc, // Program counter must load res_next_pc.
  output logic [ADDR_W-1:0] res_next_pc, // Address of the next instruction.
  output logic [ADDR_W-1:0] res_target, // Computed branch target.
  output logic [3:0] res_flags, // Condition flags after the instruction.
  output branch_kind_t res_kind // Decoded branch class.
);

  // Widths below sixteen bits cannot hold the address space that the signed and unsigned tests
  // are built around, so they are refused while the design is elaborated.
  if (ADDR_W < 16)
  begin : g_addr_w_check
    $error("branch_condition_unit: ADDR_W must be at least 16");
  end

  // Whole state of the result stage.
  typedef struct packed {
    logic valid;
    logic is_branch;
    logic taken;
    logic load_pc;
    logic [ADDR_W-1:0] next_pc;
    logic [ADDR_W-1:0] target;
    logic [3:0] flags;
    branch_kind_t kind;
  } unit_state_t;

  // Maps the opcode byte to a branch class; higher-or-same and lower share carry codes.
  function automatic branch_kind_t decode_kind(input logic [7:0] opc);
    branch_kind_t k;
    k = KIND_NONE;
    unique case (opc)
      `BCU_OPC_ALWAYS: k = KIND_ALWAYS;
      `BCU_OPC_NONZERO: k = KIND_NONZERO;
      `BCU_OPC_ZERO: k = KIND_ZERO;
      `BCU_OPC_SIGNED_GE: k = KIND_SIGNED_GE;
      `BCU_OPC_SIGNED_LT: k = KIND_SIGNED_LT;
      `BCU_OPC_SIGNED_GT: k = KIND_SIGNED_GT;
      `BCU_OPC_SIGNED_LE: k = KIND_SIGNED_LE;
      `BCU_OPC_PLUS: k = KIND_PLUS;
      `BCU_OPC_MINUS: k = KIND_MINUS;
      `BCU_OPC_UNS_HIGHER: k = KIND_UNS_HIGHER;
      `BCU_OPC_UNS_LOWER_SAME: k = KIND_UNS_LOWER_SAME;
      `BCU_OPC_OVF_CLEAR: k = KIND_OVF_CLEAR;
      `BCU_OPC_OVF_SET: k = KIND_OVF_SET;
      `BCU_OPC_UNS_HIGHER_SAME: k = KIND_CARRY_CLEAR;
      `BCU_OPC_UNS_LOWER: k = KIND_CARRY_SET;
      default: k = KIND_NONE;
    endcase
    return k;
  endfunction : decode_kind

  // Turns the 8-bit word offset into a byte displacement of full width. Bit 7 is copied into every
  // upper bit, and the zero appended at the bottom doubles the value, because the offset counts
  // words while the program counter counts bytes.
  function automatic logic [ADDR_W-1:0] word_displacement(input logic [7:0] off);
    logic [ADDR_W-1:0] d;
    d = {{(ADDR_W-9){off[`BCU_OFF_SIGN]}}, off, 1'b0};
    return d;
  endfunction : word_displacement

  // Opcode byte of every branch code; the unsigned higher-or-same and lower forms are the carry codes.
  localparam int BRANCH_CODES = 15;
  localparam logic [7:0] BRANCH_OPC [BRANCH_CODES] = '{
    `BCU_OPC_ALWAYS,
    `BCU_OPC_NONZERO,
    `BCU_OPC_ZERO,
    `BCU_OPC_SIGNED_GE,
    `BCU_OPC_SIGNED_LT,
    `BCU_OPC_SIGNED_GT,
    `BCU_OPC_SIGNED_LE,
    `BCU_OPC_PLUS,
    `BCU_OPC_MINUS,
    `BCU_OPC_UNS_HIGHER,
    `BCU_OPC_UNS_LOWER_SAME,
    `BCU_OPC_OVF_CLEAR,
    `BCU_OPC_OVF_SET,
    `BCU_OPC_CARRY_CLEAR,
    `BCU_OPC_CARRY_SET
  };

  unit_state_t state_reg;
  unit_state_t state_next;
  branch_kind_t dec_kind;
  cond_flags_t cur_flags;
  logic cond_met;
  logic [7:0] dec_opc;
  logic [7:0] dec_off;
  logic [ADDR_W-1:0] updated_pc;
  logic [ADDR_W-1:0] displacement;
  logic [ADDR_W-1:0] target_pc;
  logic [BRANCH_CODES-1:0] opc_hit;
  logic dec_is_branch;

  // Field split of the instruction word.
  assign dec_opc = dec_word[`BCU_OPC_HI:`BCU_OPC_LO];
  assign dec_off = dec_word[`BCU_OFF_HI:`BCU_OFF_LO];
  assign dec_kind = decode_kind(dec_opc);
  assign cur_flags = '{n: flag_n, z: flag_z, v: flag_v, c: flag_c};

  // One comparator per branch code; a word with no hit passes as a plain instruction.
  for (genvar i = 0; i < BRANCH_CODES; i++)
  begin : g_opc_hit
    assign opc_hit[i] = (dec_opc == BRANCH_OPC[i]);
  end
  assign dec_is_branch = |opc_hit;

  // Updated PC points at the word after the branch; the target is built from it.
  assign updated_pc = dec_addr + ADDR_W'(`BCU_WORD_STEP);
  assign displacement = word_displacement(dec_off);
  assign target_pc = updated_pc + displacement;

  // Condition test for the decoded class.
  branch_cond_eval u_cond
  (
    .kind(dec_kind),
    .flags(cur_flags),
    .cond_met(cond_met)
  );

  // Next state of the result stage.
  always_comb
  begin
    state_next = state_reg;
    state_next.valid = dec_valid;
    if (dec_valid)
    begin
      state_next.kind = dec_kind;
      state_next.is_branch = dec_is_branch;
      state_next.target = target_pc;
      state_next.taken = cond_met;
      state_next.load_pc = cond_met;
      // A failed test behaves as a no-operation and falls through.
      state_next.next_pc = cond_met ? target_pc : updated_pc;
      // Flags leave the unit exactly as they came in.
      state_next.flags = {flag_n, flag_z, flag_v, flag_c};
    end
    else
    begin
      state_next.taken = 1'b0;
      state_next.load_pc = 1'b0;
    end
  end

  // Result stage register.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= '{valid: 1'b0, is_branch: 1'b0, taken: 1'b0, load_pc: 1'b0,
                     next_pc: ADDR_W'(`BCU_RST_PC), target: ADDR_W'(`BCU_RST_PC),
                     flags: `BCU_RST_FLAGS, kind: KIND_NONE};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the result register.
  assign res_valid = state_reg.valid;
  assign res_is_branch = state_reg.is_branch;
  assign res_taken = state_reg.taken;
  assign res_load_pc = state_reg.load_pc;
  assign res_next_pc = state_reg.next_pc;
  assign res_target = state_reg.target;
  assign res_flags = state_reg.flags;
  assign res_kind = state_reg.kind;

endmodule : branch_condition_unit

// *** sim/branch_condition_unit_asserts.sv ***
`timescale 1ns/100ps
`include "branch_unit_consts.svh"
module branch_condition_unit_asserts
  import branch_unit_pkg::*;
#(
  parameter int ADDR_W = 16 // PC width.
)
(
  input wire logic clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic dec_valid, // Request.
  input wire logic [15:0] dec_word, // Word.
  input wire logic [ADDR_W-1:0] dec_addr, // Address.
  input wire logic flag_n, // N.
  input wire logic flag_z, // Z.
  input wire logic flag_v, // V.
  input wire logic flag_c, // C.
  input wire logic res_valid, // Result.
  input wire logic res_taken, // Taken.
  input wire logic res_load_pc, // Load.
  input wire logic [ADDR_W-1:0] res_next_pc, // Next.
  input wire logic [ADDR_W-1:0] res_target, // Target.
  input wire logic [3:0] res_flags // Flags.
);
  logic [ADDR_W-1:0] exp_next;
  logic [ADDR_W-1:0] exp_target;
  // Word after the branch, and that word plus the doubled, sign-extended offset.
  assign exp_next = dec_addr + ADDR_W'(2);
  assign exp_target = exp_next + {{(ADDR_W-9){dec_word[7]}}, dec_word[7:0], 1'b0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A request carrying the given opcode byte.
  sequence s_op(logic [7:0] op);
    dec_valid && dec_word[15:8] == op;
  endsequence
  valid_latency_a: assert property (dec_valid |=> res_valid)
    else $error("no result after request");
  idle_quiet_a: assert property (!dec_valid |=> !res_valid && !res_taken)
    else $error("result without request");
  load_taken_a: assert property (res_taken |-> res_valid && res_load_pc)
    else $error("taken without load");
  target_calc_a: assert property (dec_valid |=> res_target == $past(exp_target))
    else $error("wrong target");
  next_pc_a: assert property (dec_valid |=> res_next_pc == (res_taken ? $past(exp_target) : $past(exp_next)))
    else $error("wrong next address");
  flags_keep_a: assert property (dec_valid |=> res_flags == {$past(flag_n), $past(flag_z), $past(flag_v), $past(flag_c)})
    else $error("flags changed");
  always_taken_a: assert property (s_op(`BCU_OPC_ALWAYS) |=> res_taken)
    else $error("unconditional not taken");
  zero_test_a: assert property (s_op(`BCU_OPC_ZERO) |=> res_taken == $past(flag_z))
    else $error("zero test wrong");
  signed_lt_a: assert property (s_op(`BCU_OPC_SIGNED_LT) |=> res_taken == ($past(flag_n) ^ $past(flag_v)))
    else $error("signed less test wrong");
  uns_higher_a: assert property (s_op(`BCU_OPC_UNS_HIGHER) |=> res_taken == !($past(flag_c) || $past(flag_z)))
    else $error("unsigned higher test wrong");
endmodule : branch_condition_unit_asserts
bind branch_condition_unit branch_condition_unit_asserts #(.ADDR_W(ADDR_W)) chk (.clk(clk), .sys_rst(sys_rst),
  .dec_valid(dec_valid), .dec_word(dec_word), .dec_addr(dec_addr), .flag_n(flag_n), .flag_z(flag_z),
  .flag_v(flag_v), .flag_c(flag_c), .res_valid(res_valid), .res_taken(res_taken), .res_load_pc(res_load_pc),
  .res_next_pc(res_next_pc), .res_target(res_target), .res_flags(res_flags));

// *** sim/instr_source_model.sv ***
`timescale 1ns/100ps
module instr_source_model (
  input wire logic clk, // Clock.
  input wire logic req, // Slot wanted.
  input wire logic [15:0] req_word, // Word to send.
  output logic dec_valid, // Word present.
  output logic [15:0] dec_word // Word lines.
);
  logic [15:0] last_word_reg = 16'h0000;
  // Idle word lines toggle so that stale data never looks valid.
  always_ff @(posedge clk)
  begin
    last_word_reg <= dec_word;
  end
  assign dec_valid = req;
  assign dec_word = req ? req_word : ~last_word_reg;
endmodule : instr_source_model

// *** sim/branch_condition_unit_tb_top.sv ***
`timescale 1ns/100ps
module branch_condition_unit_tb_top;
  import branch_unit_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic [15:0] dec_addr = 16'h0000;
  logic [3:0] fl = 4'h0;
  logic dec_valid, res_valid, res_is_branch, res_taken, res_load_pc;
  logic [15:0] dec_word, res_next_pc, res_target;
  logic [3:0] res_flags;
  branch_kind_t res_kind;
  int err_count = 0;
  int checked = 0;
  always #5 clk = ~clk;
  instr_source_model src (.clk(clk), .req(req), .req_word(req_word), .dec_valid(dec_valid), .dec_word(dec_word));
  branch_condition_unit #(.ADDR_W(16)) dut (.clk(clk), .sys_rst(sys_rst), .dec_valid(dec_valid),
    .dec_word(dec_word), .dec_addr(dec_addr), .flag_n(fl[3]), .flag_z(fl[2]), .flag_v(fl[1]), .flag_c(fl[0]),
    .res_valid(res_valid), .res_is_branch(res_is_branch), .res_taken(res_taken), .res_load_pc(res_load_pc),
    .res_next_pc(res_next_pc), .res_target(res_target), .res_flags(res_flags), .res_kind(res_kind));
  // Counts a comparison and reports a mismatch.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Presents one word for one cycle, then lets the result settle.
  task automatic issue(input logic [15:0] w, input logic [15:0] a, input logic [3:0] f);
    @(posedge clk);
    req <= 1'b1;
    req_word <= w;
    dec_addr <= a;
    fl <= f;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask : issue
  // Expected outcome of each condition test, flags as {n,z,v,c}.
  function automatic logic exp_take(input logic [7:0] op, input logic [3:0] f);
    case (op)
      8'h01: return 1'b1;
      8'h02: return !f[2];
      8'h03: return f[2];
      8'h04: return !(f[3] ^ f[1]);
      8'h05: return f[3] ^ f[1];
      8'h06: return !(f[2] | (f[3] ^ f[1]));
      8'h07: return f[2] | (f[3] ^ f[1]);
      8'h80: return !f[3];
      8'h81: return f[3];
      8'h82: return !(f[0] | f[2]);
      8'h83: return f[0] | f[2];
      8'h84: return !f[1];
      8'h85: return f[1];
      8'h86: return !f[0];
      8'h87: return f[0];
      default: return 1'b0;
    endcase
  endfunction : exp_take
  // Expected class of each opcode byte.
  function automatic branch_kind_t exp_kind(input logic [7:0] op);
    case (op)
      8'h01: return KIND_ALWAYS;
      8'h02: return KIND_NONZERO;
      8'h03: return KIND_ZERO;
      8'h04: return KIND_SIGNED_GE;
      8'h05: return KIND_SIGNED_LT;
      8'h06: return KIND_SIGNED_GT;
      8'h07: return KIND_SIGNED_LE;
      8'h80: return KIND_PLUS;
      8'h81: return KIND_MINUS;
      8'h82: return KIND_UNS_HIGHER;
      8'h83: return KIND_UNS_LOWER_SAME;
      8'h84: return KIND_OVF_CLEAR;
      8'h85: return KIND_OVF_SET;
      8'h86: return KIND_CARRY_CLEAR;
      8'h87: return KIND_CARRY_SET;
      default: return KIND_NONE;
    endcase
  endfunction : exp_kind
  // Unconditional branches across the offset range, both extremes included.
  task automatic run_offsets();
    logic [7:0] offs [8];
    logic [15:0] exp;
    offs = '{8'hFD, 8'hFE, 8'hFF, 8'h00, 8'h01, 8'h02, 8'h80, 8'h7F};
    foreach (offs[i])
    begin
      exp = 16'h0142 + {{7{offs[i][7]}}, offs[i], 1'b0};
      issue({8'h01, offs[i]}, 16'h0140, 4'hF);
      check("target", res_target, exp);
      check("always_pc", res_next_pc, exp);
    end
  endtask : run_offsets
  // Every opcode, and one plain word, against all sixteen flag patterns.
  task automatic run_conditions();
    logic [7:0] ops [16];
    logic t;
    ops = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
      8'h87, 8'h00};
    foreach (ops[i])
      for (int f = 0; f < 16; f++)
      begin
        t = exp_take(ops[i], 4'(f));
        issue({ops[i], 8'h05}, 16'h0100, 4'(f));
        check("taken", 16'(res_taken), 16'(t));
        check("valid", 16'(res_valid), 16'h0001);
        check("load_pc", 16'(res_load_pc), 16'(t));
        check("is_branch", 16'(res_is_branch), 16'(ops[i] != 8'h00));
        check("kind", 16'(res_kind), 16'(exp_kind(ops[i])));
        check("next_pc", res_next_pc, t ? 16'h010C : 16'h0102);
        check("flags", 16'(res_flags), 16'(f));
      end
  endtask : run_conditions
  // Every result at its reset value.
  task automatic check_reset();
    check("rst_valid", 16'(res_valid), 16'h0000);
    check("rst_taken", 16'(res_taken), 16'h0000);
    check("rst_load_pc", 16'(res_load_pc), 16'h0000);
    check("rst_branch", 16'(res_is_branch), 16'h0000);
    check("rst_next_pc", res_next_pc, 16'h0000);
    check("rst_target", res_target, 16'h0000);
    check("rst_flags", 16'(res_flags), 16'h0000);
    check("rst_kind", 16'(res_kind), 16'(KIND_NONE));
  endtask : check_reset
  // Two words on consecutive edges, then idle: each result is valid for one cycle, and next_pc holds after it.
  task automatic run_back_to_back();
    @(posedge clk);
    req <= 1'b1;
    req_word <= 16'h03FE;
    dec_addr <= 16'h0200;
    fl <= 4'h4;
    @(posedge clk);
    req_word <= 16'h02FE;
    dec_addr <= 16'h0202;
    #1;
    check("b2b_first", res_next_pc, 16'h01FE);
    @(posedge clk);
    req <= 1'b0;
    #1;
    check("b2b_second", res_next_pc, 16'h0204);
    check("b2b_valid", 16'(res_valid), 16'h0001);
    @(posedge clk);
    #1;
    check("b2b_idle", 16'(res_valid), 16'h0000);
    check("b2b_taken", 16'(res_taken), 16'h0000);
    check("b2b_hold", res_next_pc, 16'h0204);
  endtask : run_back_to_back
  // Reset in mid-run clears the fields a taken branch left held after one idle cycle, and a request during reset is ignored.
  task automatic run_reset_mid();
    issue(16'h0110, 16'h0300, 4'hF);
    check("pre_reset_pc", res_next_pc, 16'h0322);
    @(posedge clk);
    sys_rst <= 1'b1;
    req <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    req <= 1'b0;
    #1;
    check_reset();
  endtask : run_reset_mid
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (15) @(posedge clk);
    #1;
    check_reset();
    @(posedge clk);
    sys_rst <= 1'b0;
    run_offsets();
    run_conditions();
    run_back_to_back();
    run_reset_mid();
    complete_run();
  end
endmodule : branch_condition_unit_tb_top
